// ==== verilog/dtmf_out_pkg.sv ====
// Constants for the tone-pair digit output port
// Overview of operation
// - With the clock source select high, run from the on-chip oscillator and drive the time base pin with the oscillator divided by eight.
// - With the clock source select low, ignore the oscillator and take the working clock from the time base pin as an input.
// - While the output drive control is high the four code lines are driven, while low they float.
// - The decoded tone pair is shown as a binary code on four lines weighted one, two, four and eight.
// - The code valid flag is high only while the code lines carry a validated tone pair.
// - The flag rises only after both tones stayed valid for a detect interval between 20 and 40 ms.
// - After a digit is flagged, tone dropouts shorter than 20 ms are ignored and flag and code hold.
// - A tone absence longer than 40 ms is a release that drops the flag and clears the code.
package dtmf_out_pkg;
    localparam int          CLK_HZ        = 125_000_000;
    localparam int          DETECT_MS     = 30;
    localparam int          DROPOUT_MS    = 20;
    localparam int          RELEASE_MS    = 40;
    localparam int          DETECT_CYC    = CLK_HZ / 1000 * DETECT_MS;
    localparam int          DROPOUT_CYC   = CLK_HZ / 1000 * DROPOUT_MS;
    localparam int          RELEASE_CYC   = CLK_HZ / 1000 * RELEASE_MS;
    localparam int          TB_DIV        = 8;
    localparam int          TB_HALF       = TB_DIV / 2;
    localparam logic [3:0]  CODE_NONE     = 4'h0;
    localparam logic [3:0]  CODE_ZERO     = 4'hA;
    localparam logic [3:0]  CODE_STAR     = 4'hB;
    localparam logic [3:0]  CODE_HASH     = 4'hC;
    localparam logic [3:0]  CODE_A        = 4'hD;
    localparam logic [3:0]  CODE_B        = 4'hE;
    localparam logic [3:0]  CODE_C        = 4'hF;
    localparam logic [3:0]  KEY_ZERO      = 4'hA;
    localparam logic [3:0]  KEY_STAR      = 4'hB;
    localparam logic [3:0]  KEY_HASH      = 4'hC;
    localparam logic [3:0]  KEY_A         = 4'hD;
    localparam logic [3:0]  KEY_B         = 4'hE;
    localparam logic [3:0]  KEY_C         = 4'hF;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          FIFO_WIDTH    = 4;
endpackage

// ==== verilog/dtmf_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dtmf_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_t;
    fifo_t            st_reg;
    fifo_t            st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Handshake terms
    assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = mem[st_reg.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State and storage registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wr] <= in_data;
        end
    end
endmodule // dtmf_fifo

// ==== verilog/dtmf_digit_output_port.sv ====
// Digit output port: detect timing, code mapping, output drive, time base
`timescale 1ns/1ps
module dtmf_digit_output_port #(
    parameter int DETECT_COUNT  = dtmf_out_pkg::DETECT_CYC,
    parameter int RELEASE_COUNT = dtmf_out_pkg::RELEASE_CYC
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       TONE_PRESENT,
    input  wire logic [3:0] TONE_KEY,
    input  wire logic       CLOCK_SOURCE_SELECT,
    input  wire logic       OUTPUT_DRIVE_EN,
    input  wire logic       ALT_TIME_BASE_IN,
    output logic            ALT_TIME_BASE_OUT,
    output logic            ALT_TIME_BASE_OE,
    output logic            TIME_BASE_TICK,
    output logic [3:0]      DIGIT_CODE_BITS_OUT,
    output logic [3:0]      DIGIT_CODE_BITS_OE,
    output logic            CODE_VALID_FLAG,
    output logic            CODE_LOST
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_QUAL  = 2'b01,
        ST_VALID = 2'b11,
        ST_DROP  = 2'b10
    } mode_t;

    typedef struct packed {
        mode_t      mode;
        logic [31:0] tmr;
        logic [3:0]  key;
        logic [3:0]  code;
        logic        valid;
        logic [3:0]  oe;
        logic [2:0]  div;
        logic        tb_out;
        logic        tb_oe;
        logic        tb_prev;
        logic        tick;
        logic        push;
        logic        lost;
    } state_t;

    state_t     st_reg;
    state_t     st_next;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [3:0] fifo_out_data;
    logic       fifo_take;

    // Keypad position to output code
    function automatic logic [3:0] map_key(input logic [3:0] k);
        logic [3:0] c;
        c = k;
        if (k == dtmf_out_pkg::KEY_ZERO) begin
            c = dtmf_out_pkg::CODE_ZERO;
        end else if (k == dtmf_out_pkg::KEY_STAR) begin
            c = dtmf_out_pkg::CODE_STAR;
        end else if (k == dtmf_out_pkg::KEY_HASH) begin
            c = dtmf_out_pkg::CODE_HASH;
        end else if (k == dtmf_out_pkg::KEY_A) begin
            c = dtmf_out_pkg::CODE_A;
        end else if (k == dtmf_out_pkg::KEY_B) begin
            c = dtmf_out_pkg::CODE_B;
        end else if (k == dtmf_out_pkg::KEY_C) begin
            c = dtmf_out_pkg::CODE_C;
        end
        return c;
    endfunction

    // Validated keypad positions queue ahead of the code mapping and output latch
    dtmf_fifo #(
        .WIDTH (dtmf_out_pkg::FIFO_WIDTH),
        .DEPTH (dtmf_out_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst       (RST),
        .in_valid  (st_reg.push),
        .in_ready  (fifo_in_ready),
        .in_data   (st_reg.key),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_out_data)
    );

    // Code latch pops the queue while no code is shown, also in a dropout
    assign fifo_take = fifo_out_valid && !st_reg.valid &&
                       (st_reg.mode == ST_VALID || (st_reg.mode == ST_DROP && !TONE_PRESENT));

    // Next state of timing, code latch, drive and time base
    always_comb begin
        st_next      = st_reg;
        st_next.push = 1'b0;
        st_next.lost = 1'b0;
        st_next.tick = 1'b0;
        case (st_reg.mode)
            ST_IDLE: begin
                st_next.tmr = '0;
                if (TONE_PRESENT) begin
                    st_next.mode = ST_QUAL;
                    st_next.key  = TONE_KEY;
                end
            end
            ST_QUAL: begin
                if (!TONE_PRESENT || TONE_KEY != st_reg.key) begin
                    st_next.mode = ST_IDLE;
                end else if (st_reg.tmr == 32'(DETECT_COUNT - 1)) begin
                    st_next.mode = ST_VALID;
                    st_next.tmr  = '0;
                    st_next.push = 1'b1;
                    st_next.lost = !fifo_in_ready;
                end else begin
                    st_next.tmr = st_reg.tmr + 32'h1;
                end
            end
            ST_VALID: begin
                st_next.tmr = '0;
                if (fifo_take) begin
                    st_next.code  = map_key(fifo_out_data);
                    st_next.valid = 1'b1;
                end
                if (!TONE_PRESENT) begin
                    st_next.mode = ST_DROP;
                end
            end
            ST_DROP: begin
                if (TONE_PRESENT) begin
                    st_next.mode = ST_VALID;
                end else if (st_reg.tmr == 32'(RELEASE_COUNT - 1)) begin
                    st_next.mode  = ST_IDLE;
                    st_next.valid = 1'b0;
                    st_next.code  = dtmf_out_pkg::CODE_NONE;
                end else begin
                    st_next.tmr = st_reg.tmr + 32'h1;
                    // A digit queued just before the dropout is still shown
                    if (fifo_take) begin
                        st_next.code  = map_key(fifo_out_data);
                        st_next.valid = 1'b1;
                    end
                end
            end
            default: begin
                st_next.mode = ST_IDLE;
            end
        endcase
        // Code line drive follows the enable input
        st_next.oe = {4{OUTPUT_DRIVE_EN}};
        // Internal mode divides by eight, external mode listens on the pin
        st_next.tb_oe   = CLOCK_SOURCE_SELECT;
        st_next.tb_prev = ALT_TIME_BASE_IN;
        if (CLOCK_SOURCE_SELECT) begin
            st_next.div    = st_reg.div + 3'h1;
            st_next.tb_out = (st_reg.div >= 3'(dtmf_out_pkg::TB_HALF - 1)) &&
                             (st_reg.div != 3'(dtmf_out_pkg::TB_DIV - 1));
            st_next.tick   = (st_reg.div == 3'(dtmf_out_pkg::TB_DIV - 1));
        end else begin
            st_next.div    = '0;
            st_next.tb_out = 1'b0;
            st_next.tick   = ALT_TIME_BASE_IN && !st_reg.tb_prev;
        end
    end

    // State register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ALT_TIME_BASE_OUT   = st_reg.tb_out;
    assign ALT_TIME_BASE_OE    = st_reg.tb_oe;
    assign TIME_BASE_TICK      = st_reg.tick;
    assign DIGIT_CODE_BITS_OUT = st_reg.code;
    assign DIGIT_CODE_BITS_OE  = st_reg.oe;
    assign CODE_VALID_FLAG     = st_reg.valid;
    assign CODE_LOST           = st_reg.lost;

    // Flag never rises while no code is held
    AST_FLAG_HAS_CODE: assert property (@(posedge CORE_CLK) disable iff (RST)
        $rose(CODE_VALID_FLAG) |-> DIGIT_CODE_BITS_OUT != dtmf_out_pkg::CODE_NONE)
        else $error("Valid flag rose with empty code");
    // Drive enable follows the control input one cycle later
    AST_DRIVE: assert property (@(posedge CORE_CLK) disable iff (RST)
        ##1 DIGIT_CODE_BITS_OE == {4{$past(OUTPUT_DRIVE_EN)}})
        else $error("Code drive does not follow enable");
    // Time base pin direction follows select
    AST_TB_DIR: assert property (@(posedge CORE_CLK) disable iff (RST)
        ##1 ALT_TIME_BASE_OE == $past(CLOCK_SOURCE_SELECT))
        else $error("Time base direction wrong");
    // Internal divider gives a tick every eight cycles
    AST_TB_DIV: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CLOCK_SOURCE_SELECT && TIME_BASE_TICK) [*1] ##1 CLOCK_SOURCE_SELECT [*7]
        |=> TIME_BASE_TICK)
        else $error("Time base period is not eight");
    // Short dropout keeps flag and code
    AST_DROP_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_reg.mode == ST_DROP && TONE_PRESENT) |=> $stable(CODE_VALID_FLAG) &&
        $stable(DIGIT_CODE_BITS_OUT))
        else $error("Dropout disturbed the output");
    // Release clears both flag and code together
    AST_RELEASE: assert property (@(posedge CORE_CLK) disable iff (RST)
        $fell(CODE_VALID_FLAG) |-> DIGIT_CODE_BITS_OUT == dtmf_out_pkg::CODE_NONE)
        else $error("Release left a code behind");
    // Qualified digit only after full detect count
    AST_DETECT: assert property (@(posedge CORE_CLK) disable iff (RST)
        st_reg.push |-> $past(st_reg.tmr) == 32'(DETECT_COUNT - 1))
        else $error("Digit qualified early");
    // Zero key maps to ten
    AST_MAP_ZERO: assert property (@(posedge CORE_CLK) disable iff (RST)
        $rose(CODE_VALID_FLAG) && $past(fifo_out_data) == dtmf_out_pkg::KEY_ZERO
        |-> DIGIT_CODE_BITS_OUT == dtmf_out_pkg::CODE_ZERO)
        else $error("Zero key mapped wrong");
    // Code lines read zero whenever the flag is low
    AST_IDLE_CODE: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CODE_VALID_FLAG |-> DIGIT_CODE_BITS_OUT == dtmf_out_pkg::CODE_NONE)
        else $error("Code shown without flag");
    // External mode leaves the pin undriven and low
    AST_TB_QUIET: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CLOCK_SOURCE_SELECT |=> !ALT_TIME_BASE_OUT && !ALT_TIME_BASE_OE)
        else $error("Pin driven in external mode");
    // A broken or changed burst goes back to idle and queues nothing
    AST_QUAL_BREAK: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_reg.mode == ST_QUAL && (!TONE_PRESENT || TONE_KEY != st_reg.key))
        |=> st_reg.mode == ST_IDLE && !st_reg.push)
        else $error("Broken burst was queued");
    // Release lands on the last count of an unbroken absence
    AST_RELEASE_TIME: assert property (@(posedge CORE_CLK) disable iff (RST)
        (st_reg.mode == ST_DROP && !TONE_PRESENT &&
         st_reg.tmr == 32'(RELEASE_COUNT - 1)) |=> !CODE_VALID_FLAG)
        else $error("Release count ran out without release");
endmodule // dtmf_digit_output_port

// ==== bench/host_model.sv ====
// Host model: latches digit codes and supplies the external time base
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       flag,
    input  wire logic [3:0] code,
    input  wire logic       ext_en,
    output logic            ext_clk,
    output logic [3:0]      latched,
    output int              strobes,
    output int              slips
);
    logic flag_q;
    int   div;
    // Latch on the flag's rising edge, watch the code while it stands
    always_ff @(posedge clk) begin
        flag_q <= flag;
        if (rst) begin
            strobes <= 0;
            slips <= 0;
            latched <= 4'h0;
        end else if (flag && !flag_q) begin
            latched <= code;
            strobes <= strobes + 1;
        end else if (flag && code !== latched) begin
            slips <= slips + 1;
        end
    end
    // Time base source, pattern changes every cycle while released
    always_ff @(posedge clk) begin
        if (rst) begin
            div <= 0;
            ext_clk <= 1'b0;
        end else if (!ext_en) begin
            div <= 0;
            ext_clk <= ~ext_clk;
        end else begin
            div <= (div == 279) ? 0 : div + 1;
            ext_clk <= (div >= 139);
        end
    end
endmodule // host_model

// ==== bench/test_dtmf_digit_output_port.sv ====
// Testbench for the digit output port
`timescale 1ns/1ps
module test_dtmf_digit_output_port;
    // Short detect and release counts keep the run brief
    localparam int DET = 600;
    localparam int REL = 800;
    logic       clk, rst, tone, sel, en, ext_en, pin, tb_out, tb_oe, tick, flag, lost;
    logic       ext_clk, out_q;
    logic [3:0] key, code, code_oe, latched, want;
    int         strobes, slips, ticks, outrise, t0, o0, len, errors, compares, r;

    dtmf_digit_output_port #(
        .DETECT_COUNT  (DET),
        .RELEASE_COUNT (REL)
    ) dtmf_digit_output_port_inst (
        .CORE_CLK            (clk),
        .RST                 (rst),
        .TONE_PRESENT        (tone),
        .TONE_KEY            (key),
        .CLOCK_SOURCE_SELECT (sel),
        .OUTPUT_DRIVE_EN     (en),
        .ALT_TIME_BASE_IN    (pin),
        .ALT_TIME_BASE_OUT   (tb_out),
        .ALT_TIME_BASE_OE    (tb_oe),
        .TIME_BASE_TICK      (tick),
        .DIGIT_CODE_BITS_OUT (code),
        .DIGIT_CODE_BITS_OE  (code_oe),
        .CODE_VALID_FLAG     (flag),
        .CODE_LOST           (lost)
    );
    host_model host_model_inst (
        .clk     (clk),
        .rst     (rst),
        .flag    (flag),
        .code    (code),
        .ext_en  (ext_en),
        .ext_clk (ext_clk),
        .latched (latched),
        .strobes (strobes),
        .slips   (slips)
    );
    // Shared pin level from both drivers
    assign pin = tb_oe ? tb_out : ext_clk;

    always #4 clk = ~clk;
    // Tick and divider edge counters
    always @(posedge clk) begin
        ticks <= ticks + tick;
        out_q <= tb_out;
        outrise <= outrise + (tb_out & !out_q);
    end

    function automatic int exp_ticks(input int cycles, input int period);
        return cycles / period;
    endfunction

    // Code a host expects for a keypad position
    function automatic logic [3:0] exp_code(input logic [3:0] k);
        if (k == dtmf_out_pkg::KEY_ZERO) return 4'hA;
        if (k == dtmf_out_pkg::KEY_STAR) return 4'hB;
        if (k == dtmf_out_pkg::KEY_HASH) return 4'hC;
        if (k == dtmf_out_pkg::KEY_A) return 4'hD;
        if (k == dtmf_out_pkg::KEY_B) return 4'hE;
        if (k == dtmf_out_pkg::KEY_C) return 4'hF;
        return k;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk = 0; rst = 1; tone = 0; key = 4'h1; sel = 0; en = 0; ext_en = 0;
        ticks = 0; outrise = 0; out_q = 0; errors = 0; compares = 0;
        r = $urandom(98883);
        repeat (3) @(posedge clk);
        #1 rst = 0;
        check({flag, lost, code, code_oe, tb_oe, tb_out, tick}, 16'h0000, "reset outputs");
        $display("test reset done");
        // Internal oscillator drives the pin at one eighth
        sel = 1;
        step(1);
        check(tb_oe, 1'b1, "pin not driven");
        step(16);
        t0 = ticks;
        o0 = outrise;
        step(800);
        check(16'(ticks - t0), 16'(exp_ticks(800, 8)), "internal tick count");
        check(16'(outrise - o0), 16'(exp_ticks(800, 8)), "pin clock count");
        $display("test internal time base done");
        // External time base on the pin
        sel = 0;
        ext_en = 1;
        step(1);
        check({tb_oe, tb_out}, 2'b00, "pin still driven");
        step(3);
        t0 = ticks;
        step(2796);
        check(16'(ticks - t0), 16'(exp_ticks(2800, 280)), "external tick count");
        $display("test external time base done");
        // Bursts too short, broken or with a key change, never flagged
        for (int i = 0; i < 24; i++) begin
            en = 1'($urandom);
            key = 4'(1 + $urandom % 15);
            tone = 1;
            len = 1 + $urandom % (DET / 2);
            if (i == 2) len = DET / 2;
            step(len);
            if (i % 3 == 0) key = (key == 4'hF) ? 4'h1 : key + 4'h1;
            if (i % 3 == 1) begin
                tone = 0;
                step(5);
                tone = 1;
            end
            step(len);
            tone = 0;
            step(1);
            check(code_oe, {4{en}}, "code line drive");
            check({flag, code, lost}, 6'h00, "early flag or code");
            step(1 + $urandom % 500);
        end
        check(16'(strobes), 16'h0000, "host saw a digit");
        check(16'(slips), 16'h0000, "code moved under flag");
        $display("test refused bursts done");
        // Valid digits: exact detect count, short dropout, release
        for (int i = 0; i < 10; i++) begin
            en = 1'($urandom);
            key = (i < 6) ? 4'(4'hA + i) : 4'(1 + $urandom % 9);
            want = exp_code(key);
            tone = 1;
            step(DET + 2);
            check(flag, 1'b0, "flag before detect count");
            step(1);
            check({flag, code}, {1'b1, want}, "digit shown");
            check(code_oe, {4{en}}, "code line drive");
            tone = 0;
            step(1 + $urandom % (REL / 2));
            tone = 1;
            step(2);
            check({flag, code}, {1'b1, want}, "dropout disturbed digit");
            check(latched, want, "host latch");
            tone = 0;
            step(REL);
            check(flag, 1'b1, "early release");
            step(1);
            check({flag, code}, 5'h00, "release left code");
            step(1 + $urandom % 100);
        end
        check(16'(strobes), 16'h000A, "host strobe count");
        check(16'(slips), 16'h0000, "code moved under flag");
        $display("test valid digits done");
        results;
    end
endmodule // test_dtmf_digit_output_port
